/* cca_filter_bandwidth_control.sv */
// CCA receive filter bandwidth selection and infinity-mode clear detection
//=============================================================
// Overview of operation
// - Entering CCA receive loads filter width from receive config bits 7:6.
// - Timer mode, auto switch set: begin command selects CCA filter width.
// - Timer mode: expiry, halt, enter-receive or reverting preamble restore width.
// - Timer mode, no preamble revert: hold width until packet ends.
// - False preamble: CCA width if auto switch in timer mode, else stored receive width.
// - Without preamble revert, a false preamble still sets width as above.
// - Period select seven enters infinity mode; assess until channel clear.
// - Infinity: interrupt after 128 us clear, stay receiving, restore filter.
// - Clear interrupt while still clear: raise again after another 128 us.
// - With diversity, interrupt needs both antennas clear, at least 250 us.
// - Infinity accepts packets; returns to CCA receive or radio-on idle.
// - Wide filter command applies primary config bits 6:5, restarts receive.
// - Intermediate frequency 200 or 300 kHz follows chosen filter width.
// - Infinity: halt, enter-receive or reverting preamble restore width.
// - Infinity without preamble revert: hold CCA width during the packet.
// - Infinity false preamble restores default; host reissues wide filter.
// - Receive progress bit 0 preamble, bit 1 delimiter; both cleared at reception end.
`timescale 1ns/1ps
module cca_filter_bandwidth_control
  import cca_filter_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire cca_filter_pkg::reg_req_t regReq,
  output logic [7:0]                    regRdata,
  input  wire logic                     cmdValid,
  input  wire logic [7:0]               cmdCode,
  input  wire cca_filter_pkg::radio_ev_t radioEvIn,
  output logic [1:0]                    filterWidth,
  output logic                          ifSelect300,
  output logic                          rxRestart,
  output logic                          ccaReceiveState,
  output logic                          infinityMode,
  output logic                          channelAssessmentIrq
);
  import cca_filter_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CCA_RX = 3'b010,
    ST_PACKET = 3'b100
  } rx_state_t;

  //=============================================================
  // Input synchronisers
  radio_ev_t evMeta;
  radio_ev_t ev;
  always_ff @(posedge sys_clk) begin
    evMeta <= radioEvIn;
    ev <= evMeta;
  end

  //=============================================================
  // Registers
  logic [7:0] cfgPrimary;
  logic [7:0] cfgSecondary;
  logic [7:0] rxFilterCfg;
  logic [1:0] rxProgress;
  logic       timerRun;
  rx_state_t  state;
  logic [13:0] clearCnt;
  logic       irqPend;

  wire wrPri = regReq.wr && (regReq.addr == ADDR_CCA_CFG_PRI);
  wire wrSec = regReq.wr && (regReq.addr == ADDR_CCA_CFG_SEC);
  wire wrRxf = regReq.wr && (regReq.addr == ADDR_RX_FILTER);
  wire wrCtrl = regReq.wr && (regReq.addr == ADDR_CTRL);

  wire [1:0] rxWidth = rxFilterCfg[RXW_HI:RXW_LO];
  wire [1:0] ccaWidth = cfgPrimary[CCAW_HI:CCAW_LO];
  wire autoSwitch = cfgSecondary[AUTO_SW_BIT];
  wire revertPre = cfgSecondary[REVERT_PRE_BIT];
  wire infinity = cfgPrimary[PERIOD_HI:PERIOD_LO] == PERIOD_INFINITY;
  wire inCca = state == ST_CCA_RX;

  wire cmdEnter = cmdValid && cmdCode == CMD_ENTER_RX;
  wire cmdBegin = cmdValid && cmdCode == CMD_CCA_BEGIN && inCca;
  wire cmdHalt = cmdValid && cmdCode == CMD_CCA_HALT;
  wire cmdWide = cmdValid && cmdCode == CMD_WIDE_FILTER && state != ST_IDLE;

  wire preDet = ev.preamble && inCca;
  wire sfdDet = ev.sfd && state == ST_PACKET;
  wire falsePre = ev.falsePreamble && state == ST_PACKET;
  wire pktEnd = ev.packetEnd && state == ST_PACKET;
  // Expiry inside a packet must not disturb the held width
  wire timerOut = ev.timerExpired && timerRun && !infinity && inCca;

  // Clear-time threshold depends on diversity
  wire [13:0] clearNeed = ev.diversityOn ? 14'(DIV_CYC) : 14'(CLEAR_CYC);
  wire clearDone = clearCnt >= clearNeed;
  wire clearCount = infinity && inCca && !ev.channelBusy && !irqPend;
  wire [13:0] next_clearCnt = clearCount ? (clearDone ? clearCnt
                                            : clearCnt + 14'h0001)
                                          : 14'h0000;
  wire clearFire = clearCount && clearDone && !ev.irqMask;

  // Filter width priority: commands first, then events
  logic [1:0] next_width;
  always_comb begin
    next_width = filterWidth;
    if (cmdEnter || cmdHalt) begin
      next_width = rxWidth;
    end else if (cmdWide) begin
      next_width = ccaWidth;
    end else if (cmdBegin && autoSwitch && !infinity) begin
      next_width = ccaWidth;
    end else if (falsePre) begin
      next_width = (autoSwitch && !infinity) ? ccaWidth : rxWidth;
    end else if (preDet && revertPre) begin
      next_width = rxWidth;
    end else if (pktEnd && !infinity) begin
      next_width = rxWidth;
    end else if (timerOut || clearFire) begin
      next_width = rxWidth;
    end
  end

  rx_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cmdEnter) begin
          next_state = ST_CCA_RX;
        end
      end
      ST_CCA_RX: begin
        if (cmdHalt && !timerRun && !infinity) begin
          next_state = ST_CCA_RX;
        end else if (preDet) begin
          next_state = ST_PACKET;
        end
      end
      ST_PACKET: begin
        if (cmdEnter || cmdWide || falsePre) begin
          next_state = ST_CCA_RX;
        end else if (pktEnd) begin
          next_state = ev.continuousRx ? ST_CCA_RX : ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  //=============================================================
  // Sequential state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfgPrimary <= RESET_BYTE;
      cfgSecondary <= RESET_BYTE;
      rxFilterCfg <= RESET_BYTE;
    end else begin
      if (wrPri) cfgPrimary <= regReq.wdata;
      if (wrSec) cfgSecondary <= regReq.wdata;
      if (wrRxf) rxFilterCfg <= regReq.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      filterWidth <= 2'h0;
      timerRun <= 1'b0;
      clearCnt <= 14'h0000;
    end else begin
      state <= next_state;
      filterWidth <= next_width;
      timerRun <= cmdBegin ? 1'b1
                : (cmdHalt || cmdEnter || timerOut || sfdDet) ? 1'b0
                : timerRun;
      clearCnt <= next_clearCnt;
    end
  end

  // Sticky irq, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irqPend <= 1'b0;
    end else if (clearFire) begin
      irqPend <= 1'b1;
    end else if ((wrCtrl && regReq.wdata[0]) || ev.irqClear) begin
      irqPend <= 1'b0;
    end
  end

  // Progress bits: preamble bit 0, delimiter bit 1
  always_ff @(posedge sys_clk) begin
    if (sys_rst || cmdEnter || cmdWide || pktEnd || falsePre) begin
      rxProgress <= 2'b00;
    end else begin
      if (preDet) rxProgress[0] <= 1'b1;
      if (sfdDet) rxProgress[1] <= 1'b1;
    end
  end

  //=============================================================
  // Outputs and read port
  wire [7:0] rdMux =
    (regReq.addr == ADDR_RX_PROGRESS) ? {6'h00, rxProgress} :
    (regReq.addr == ADDR_CCA_CFG_PRI) ? cfgPrimary :
    (regReq.addr == ADDR_CCA_CFG_SEC) ? cfgSecondary :
    (regReq.addr == ADDR_RX_FILTER) ? rxFilterCfg :
    (regReq.addr == ADDR_STATUS) ? {3'h0, ev.channelBusy, infinity,
                                    irqPend, filterWidth} :
    8'h00;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      regRdata <= 8'h00;
      ifSelect300 <= 1'b0;
      rxRestart <= 1'b0;
      ccaReceiveState <= 1'b0;
      infinityMode <= 1'b0;
      channelAssessmentIrq <= 1'b0;
    end else begin
      regRdata <= regReq.rd ? rdMux : 8'h00;
      ifSelect300 <= next_width >= IF_SEL_WIDE;
      rxRestart <= cmdWide || cmdEnter;
      ccaReceiveState <= next_state == ST_CCA_RX;
      infinityMode <= infinity;
      channelAssessmentIrq <= irqPend;
    end
  end

  //=============================================================
  // Checks
  property p_begin_switch;
    @(posedge sys_clk) disable iff (sys_rst)
    (cmdBegin && autoSwitch && !infinity && !cmdHalt)
      |=> filterWidth == $past(ccaWidth);
  endproperty
  a_begin_switch: assert property (p_begin_switch)
    else $error("CCA width not applied on begin");

  property p_halt_restore;
    @(posedge sys_clk) disable iff (sys_rst)
    (cmdHalt || cmdEnter) |=> filterWidth == $past(rxWidth);
  endproperty
  a_halt_restore: assert property (p_halt_restore)
    else $error("Receive width not restored");

  property p_wide_restart;
    @(posedge sys_clk) disable iff (sys_rst)
    (cmdWide && !cmdHalt) |=> rxRestart && filterWidth == $past(ccaWidth);
  endproperty
  a_wide_restart: assert property (p_wide_restart)
    else $error("Wide filter not applied");

  property p_hold_packet;
    @(posedge sys_clk) disable iff (sys_rst)
    (state == ST_PACKET && !revertPre && !cmdValid && !falsePre && !pktEnd)
      |=> $stable(filterWidth);
  endproperty
  a_hold_packet: assert property (p_hold_packet)
    else $error("Width changed during packet");

  property p_irq_time;
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(irqPend) |-> $past(clearCnt) >= 14'(CLEAR_CYC);
  endproperty
  a_irq_time: assert property (p_irq_time)
    else $error("Interrupt before minimum clear time");

  property p_irq_out;
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(irqPend) |=> channelAssessmentIrq;
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("Interrupt output missing");

  property p_if_follow;
    @(posedge sys_clk) disable iff (sys_rst)
    ##1 ifSelect300 == (filterWidth >= IF_SEL_WIDE);
  endproperty
  a_if_follow: assert property (p_if_follow)
    else $error("IF select mismatch");

  property p_progress_clear;
    @(posedge sys_clk) disable iff (sys_rst)
    pktEnd |=> rxProgress == 2'b00;
  endproperty
  a_progress_clear: assert property (p_progress_clear)
    else $error("Progress bits not cleared");

  property p_enter_state;
    @(posedge sys_clk) disable iff (sys_rst)
    (cmdEnter && state == ST_IDLE) |=> ccaReceiveState;
  endproperty
  a_enter_state: assert property (p_enter_state)
    else $error("CCA receive state not entered");

  property p_timer_restore;
    @(posedge sys_clk) disable iff (sys_rst)
    (timerOut && !cmdValid) |=> filterWidth == $past(rxWidth);
  endproperty
  a_timer_restore: assert property (p_timer_restore)
    else $error("Width not restored on timer expiry");

  property p_false_auto;
    @(posedge sys_clk) disable iff (sys_rst)
    (falsePre && autoSwitch && !infinity && !cmdValid)
      |=> filterWidth == $past(ccaWidth);
  endproperty
  a_false_auto: assert property (p_false_auto)
    else $error("CCA width not applied after false preamble");

  property p_false_rx;
    @(posedge sys_clk) disable iff (sys_rst)
    (falsePre && !(autoSwitch && !infinity) && !cmdValid)
      |=> filterWidth == $past(rxWidth);
  endproperty
  a_false_rx: assert property (p_false_rx)
    else $error("Receive width not applied after false preamble");

  property p_pre_revert;
    @(posedge sys_clk) disable iff (sys_rst)
    (preDet && revertPre && !cmdValid) |=> filterWidth == $past(rxWidth);
  endproperty
  a_pre_revert: assert property (p_pre_revert)
    else $error("Width not restored on preamble");

  property p_packet_end;
    @(posedge sys_clk) disable iff (sys_rst)
    (pktEnd && !infinity && !cmdValid) |=> filterWidth == $past(rxWidth);
  endproperty
  a_packet_end: assert property (p_packet_end)
    else $error("Width not restored at packet end");

  property p_clear_restore;
    @(posedge sys_clk) disable iff (sys_rst)
    (clearFire && !cmdValid) |=> irqPend && filterWidth == $past(rxWidth);
  endproperty
  a_clear_restore: assert property (p_clear_restore)
    else $error("Clear channel did not restore width");

  property p_div_time;
    @(posedge sys_clk) disable iff (sys_rst)
    ($rose(irqPend) && $past(ev.diversityOn))
      |-> $past(clearCnt) >= 14'(DIV_CYC);
  endproperty
  a_div_time: assert property (p_div_time)
    else $error("Diversity interrupt before minimum clear time");

  property p_mask_block;
    @(posedge sys_clk) disable iff (sys_rst)
    (ev.irqMask && !irqPend) |=> !irqPend;
  endproperty
  a_mask_block: assert property (p_mask_block)
    else $error("Masked interrupt raised");

  property p_restart_cause;
    @(posedge sys_clk) disable iff (sys_rst)
    rxRestart |-> $past(cmdWide) || $past(cmdEnter);
  endproperty
  a_restart_cause: assert property (p_restart_cause)
    else $error("Receive restart without command");

  property p_infinity_out;
    @(posedge sys_clk) disable iff (sys_rst)
    1'b1 |=> infinityMode == $past(infinity);
  endproperty
  a_infinity_out: assert property (p_infinity_out)
    else $error("Infinity mode output mismatch");

  property p_state_out;
    @(posedge sys_clk) disable iff (sys_rst)
    1'b1 |=> ccaReceiveState == (state == ST_CCA_RX);
  endproperty
  a_state_out: assert property (p_state_out)
    else $error("CCA receive state output mismatch");
endmodule // cca_filter_bandwidth_control

/* cca_filter_pkg.sv */
// Constants and types shared by the CCA filter bandwidth control block
package cca_filter_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned CLEAR_MIN_US = 128;
  localparam int unsigned CLEAR_DIV_US = 250;
  localparam int unsigned CLEAR_CYC = CLEAR_MIN_US * (CLK_HZ / 1000000);
  localparam int unsigned DIV_CYC = CLEAR_DIV_US * (CLK_HZ / 1000000);
  localparam logic [8:0] ADDR_RX_PROGRESS = 9'h01F;
  localparam logic [8:0] ADDR_CCA_CFG_PRI = 9'h103;
  localparam logic [8:0] ADDR_CCA_CFG_SEC = 9'h104;
  localparam logic [8:0] ADDR_RX_FILTER = 9'h115;
  localparam logic [8:0] ADDR_CTRL = 9'h1F0;
  localparam logic [8:0] ADDR_STATUS = 9'h1F1;
  localparam logic [7:0] CMD_ENTER_RX = 8'hB2;
  localparam logic [7:0] CMD_CCA_BEGIN = 8'hB7;
  localparam logic [7:0] CMD_CCA_HALT = 8'hB8;
  localparam logic [7:0] CMD_WIDE_FILTER = 8'hB9;
  localparam int RXW_HI = 7;
  localparam int RXW_LO = 6;
  localparam int CCAW_HI = 6;
  localparam int CCAW_LO = 5;
  localparam int MANUAL_TX_BIT = 4;
  localparam int PERIOD_HI = 2;
  localparam int PERIOD_LO = 0;
  localparam int AUTO_SW_BIT = 5;
  localparam int REVERT_PRE_BIT = 4;
  localparam logic [2:0] PERIOD_INFINITY = 3'h7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] IF_SEL_WIDE = 2'h2;
  localparam logic [7:0] CMD_NONE = 8'h00;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic preamble;
    logic sfd;
    logic falsePreamble;
    logic packetEnd;
    logic timerExpired;
    logic channelBusy;
    logic diversityOn;
    logic continuousRx;
    logic irqClear;
    logic irqMask;
  } radio_ev_t;
endpackage

/* cca_host_model.sv */
// Host controller model driving register and command strobes
`timescale 1ns/1ps
module cca_host_model
  import cca_filter_pkg::*;
(
  input  wire logic                sys_clk,
  output cca_filter_pkg::reg_req_t regReq,
  output logic                     cmdValid,
  output logic [7:0]               cmdCode
);
  initial begin
    regReq = '0;
    cmdValid = 1'b0;
    cmdCode = CMD_NONE;
  end
  // One-cycle register strobe, read when r is set
  task automatic xfer(input logic [8:0] a, input logic [7:0] d,
                      input logic r);
    @(posedge sys_clk);
    regReq <= '{a, d, !r, r};
    @(posedge sys_clk);
    regReq <= '0;
  endtask
  // Only called between packets, never at a preamble start
  task automatic cmd(input logic [7:0] c);
    @(posedge sys_clk);
    cmdValid <= 1'b1;
    cmdCode <= c;
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    cmdCode <= CMD_NONE;
  endtask
  // Wide filter while still timed, then infinity with manual transmit
  task automatic goInfinity(input logic [7:0] cfg);
    cmd(CMD_WIDE_FILTER);
    xfer(ADDR_CCA_CFG_PRI, cfg | 8'h17, 1'b0);
  endtask
endmodule // cca_host_model

/* cca_filter_bandwidth_control_tb.sv */
// Self-checking bench for the CCA filter bandwidth control block
`timescale 1ns/1ps
module cca_filter_bandwidth_control_tb;
  import cca_filter_pkg::*;
  localparam int PRE = 9;
  localparam int SFD = 8;
  localparam int FPR = 7;
  localparam int PEND = 6;
  localparam int TEXP = 5;
  logic       sys_clk;
  logic       sys_rst;
  reg_req_t   regReq;
  logic [7:0] regRdata;
  logic       cmdValid;
  logic [7:0] cmdCode;
  radio_ev_t  ev;
  logic [1:0] filterWidth;
  logic       ifSelect300;
  logic       rxRestart;
  logic       ccaReceiveState;
  logic       infinityMode;
  logic       channelAssessmentIrq;
  int         n_fail;
  int         n_compared;
  int         cyc;
  logic       rdSeen;
  logic [7:0] expQ[$];
  logic [7:0] rnd;
  logic [1:0] rw;
  logic [1:0] cw;

  cca_filter_bandwidth_control dut_u (.sys_clk, .sys_rst, .regReq,
    .regRdata, .cmdValid, .cmdCode, .radioEvIn(ev), .filterWidth,
    .ifSelect300, .rxRestart, .ccaReceiveState, .infinityMode,
    .channelAssessmentIrq);
  cca_host_model host_u (.sys_clk, .regReq, .cmdValid, .cmdCode);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host_u.xfer(a, 8'h00, 1'b1);
  endtask
  task automatic cmdW(input logic [7:0] c, input logic [1:0] w);
    host_u.cmd(c);
    #1;
    chk(8'(filterWidth), 8'(w));
    chk(8'(ifSelect300), 8'(w >= IF_SEL_WIDE));
  endtask
  task automatic evW(input int b, input logic [1:0] w);
    @(posedge sys_clk);
    ev[b] <= 1'b1;
    @(posedge sys_clk);
    ev[b] <= 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    chk(8'(filterWidth), 8'(w));
  endtask
  task automatic waitIrq(input int lo);
    int n;
    n = 0;
    while (channelAssessmentIrq !== 1'b1 && n < lo + 20) begin
      @(posedge sys_clk);
      n++;
    end
    chk(8'(n >= lo && n <= lo + 8), 8'h01);
  endtask

  // Read data checked one cycle after each read strobe
  always @(posedge sys_clk) begin
    if (rdSeen) chk(regRdata, expQ.pop_front());
    rdSeen <= regReq.rd;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      tally_and_finish;
    end
  end

  initial begin
    sys_rst = 1'b1;
    ev = '0;
    ev.continuousRx = 1'b1;
    rdSeen = 1'b0;
    n_fail = 0;
    n_compared = 0;
    cyc = 0;
    rnd = lfsr(lfsr(8'h38));
    rw = rnd[1:0];
    cw = rw ^ ((rnd[3:2] == 2'h0) ? 2'h1 : rnd[3:2]);
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(ADDR_RX_PROGRESS, RESET_BYTE);
    rd(ADDR_CCA_CFG_PRI, RESET_BYTE);
    rd(ADDR_CCA_CFG_SEC, RESET_BYTE);
    rd(ADDR_RX_FILTER, RESET_BYTE);
    rd(9'h0AA, 8'h00);
    host_u.xfer(ADDR_RX_FILTER, {rw, 6'h00}, 1'b0);
    host_u.xfer(ADDR_CCA_CFG_PRI, {1'b0, cw, 5'h01}, 1'b0);
    rd(ADDR_CCA_CFG_PRI, {1'b0, cw, 5'h01});
    host_u.xfer(ADDR_CCA_CFG_SEC, 8'h30, 1'b0);
    host_u.xfer(ADDR_RX_PROGRESS, 8'hFF, 1'b0);
    rd(ADDR_RX_PROGRESS, 8'h00);
    cmdW(CMD_ENTER_RX, rw);
    chk(8'({ccaReceiveState, rxRestart}), 8'h03);
    cmdW(CMD_CCA_BEGIN, cw);
    evW(TEXP, rw);
    cmdW(CMD_CCA_BEGIN, cw);
    cmdW(CMD_CCA_HALT, rw);
    cmdW(CMD_CCA_BEGIN, cw);
    evW(PRE, rw);
    evW(PEND, rw);
    cmdW(CMD_CCA_BEGIN, cw);
    cmdW(CMD_ENTER_RX, rw);
    host_u.xfer(ADDR_CCA_CFG_SEC, 8'h20, 1'b0);
    cmdW(CMD_CCA_BEGIN, cw);
    evW(PRE, cw);
    rd(ADDR_RX_PROGRESS, 8'h01);
    evW(SFD, cw);
    rd(ADDR_RX_PROGRESS, 8'h03);
    evW(PEND, rw);
    rd(ADDR_RX_PROGRESS, 8'h00);
    chk(8'(ccaReceiveState), 8'h01);
    cmdW(CMD_CCA_BEGIN, cw);
    evW(PRE, cw);
    evW(FPR, cw);
    host_u.xfer(ADDR_CCA_CFG_SEC, 8'h00, 1'b0);
    evW(PRE, cw);
    evW(FPR, rw);
    @(posedge sys_clk);
    ev.channelBusy <= 1'b1;
    host_u.goInfinity({1'b0, cw, 5'h00});
    @(posedge sys_clk);
    #1;
    chk(8'({infinityMode, filterWidth}), 8'({1'b1, cw}));
    @(posedge sys_clk);
    ev.channelBusy <= 1'b0;
    waitIrq(CLEAR_CYC);
    rd(ADDR_STATUS, {6'h03, rw});
    host_u.xfer(ADDR_CTRL, 8'h01, 1'b0);
    @(posedge sys_clk);
    #1;
    chk(8'(channelAssessmentIrq), 8'h00);
    waitIrq(CLEAR_CYC - 4);
    @(posedge sys_clk);
    ev.irqMask <= 1'b1;
    host_u.xfer(ADDR_CTRL, 8'h01, 1'b0);
    repeat (CLEAR_CYC + 40) @(posedge sys_clk);
    chk(8'(channelAssessmentIrq), 8'h00);
    ev.channelBusy <= 1'b1;
    ev.diversityOn <= 1'b1;
    ev.irqMask <= 1'b0;
    repeat (8) @(posedge sys_clk);
    ev.channelBusy <= 1'b0;
    waitIrq(DIV_CYC);
    cmdW(CMD_WIDE_FILTER, cw);
    evW(PRE, cw);
    evW(FPR, rw);
    cmdW(CMD_WIDE_FILTER, cw);
    cmdW(CMD_CCA_HALT, rw);
    cmdW(CMD_WIDE_FILTER, cw);
    host_u.xfer(ADDR_CCA_CFG_SEC, 8'h10, 1'b0);
    evW(PRE, rw);
    rd(ADDR_RX_PROGRESS, 8'h01);
    evW(PEND, rw);
    cmdW(CMD_WIDE_FILTER, cw);
    host_u.xfer(ADDR_CCA_CFG_SEC, 8'h00, 1'b0);
    evW(PRE, cw);
    @(posedge sys_clk);
    ev.continuousRx <= 1'b0;
    evW(PEND, cw);
    chk(8'(ccaReceiveState), 8'h00);
    tally_and_finish;
  end
endmodule // cca_filter_bandwidth_control_tb
